// *** verilog/tmo_defs.svh ***
`ifndef TMO_DEFS_SVH
`define TMO_DEFS_SVH

// register indices on the plain register port
`define TMO_ADDR_W 3
`define TMO_REG_LOW 3'h0
`define TMO_REG_HIGH 3'h1
`define TMO_REG_CTRL 3'h2
`define TMO_REG_FLAGS 3'h3
`define TMO_REG_ENABLES 3'h4
`define TMO_REG_PRIORITY 3'h5

// control register field positions
`define TMO_CTRL_WIDE_BIT 7
`define TMO_CTRL_SYSCLK_BIT 6
`define TMO_CTRL_PRESCALE_HI 5
`define TMO_CTRL_PRESCALE_LO 4
`define TMO_CTRL_OSCEN_BIT 3
`define TMO_CTRL_NOSYNC_BIT 2
`define TMO_CTRL_CLKSEL_BIT 1
`define TMO_CTRL_ON_BIT 0

// overflow bit inside the flag, enable and priority registers
`define TMO_OVF_BIT 0

// reset values
`define TMO_CTRL_RESET 8'h00
`define TMO_COUNT_RESET 16'h0000
`define TMO_BYTE_RESET 8'h00
`define TMO_COUNT_MAX 16'hFFFF

// compare unit mode that fires the special event trigger
`define TMO_CMP_MODE_TRIGGER 4'hB

// prescaler counter width (largest division is 8)
`define TMO_PRESCALE_W 3

`endif

// *** verilog/tmo_pkg.sv ***
package tmo_pkg;

  typedef enum logic [1:0] {
    TMO_DIV1 = 2'b00,
    TMO_DIV2 = 2'b01,
    TMO_DIV4 = 2'b10,
    TMO_DIV8 = 2'b11
  } tmo_prescale_t;

  typedef struct packed {
    logic wideAccessMode;
    logic systemClockFromLpOsc;
    tmo_prescale_t inputPrescaleSelect;
    logic lpOscEnable;
    logic extClockSyncDisable;
    logic clockSourceSelect;
    logic counterOn;
  } tmo_ctrl_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmo_bus_t;

endpackage

// *** verilog/tmo_prescaler.sv ***
`timescale 1ns/1ps
`include "tmo_defs.svh"

module tmo_prescaler
  import tmo_pkg::*;
#(
  parameter int CNT_W = `TMO_PRESCALE_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // control
  input wire logic clear,
  input wire tmo_prescale_t divSelect,
  // ticks
  input wire logic tickIn,
  output logic tickOut
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] terminal;
  logic atTerminal;

  function automatic logic [CNT_W-1:0] div_terminal(input tmo_prescale_t sel);
    unique case (sel)
      TMO_DIV1: div_terminal = CNT_W'(0);
      TMO_DIV2: div_terminal = CNT_W'(1);
      TMO_DIV4: div_terminal = CNT_W'(3);
      TMO_DIV8: div_terminal = CNT_W'(7);
    endcase
  endfunction

  assign terminal = div_terminal(divSelect);
  assign atTerminal = (count >= terminal);
  assign tickOut = tickIn && atTerminal && !clear;

  // a clear wins over a pending tick so a low-byte write restarts the division cleanly
  always_ff @(posedge mclk) begin
    if (srst || clear) begin
      count <= '0;
    end else if (tickIn) begin
      count <= atTerminal ? '0 : count + CNT_W'(1);
    end
  end

endmodule

// *** verilog/tmo_timer.sv ***
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "tmo_defs.svh"

// Notes on behaviour
// - counter counts up from 0000 to FFFF and wraps to zero.
// - each wrap from FFFF to 0000 sets the sticky overflow flag.
// - overflow request leaves only while its enable bit is set.
// - compare unit in trigger mode resets the counter when it fires.
// - a trigger-driven reset never sets the overflow flag.
// - a software counter write in the trigger cycle wins over the reset.
// - with trigger resets, the compare pair sets the counting period.
// - wide access mode maps the high-byte address onto a buffer.
// - wide mode low-byte read copies the live high byte into the buffer.
// - wide mode low-byte write loads the high byte from the buffer.
// - wide mode keeps software away from the live high byte.
// - high-byte writes keep the prescaler; low-byte writes clear it.
// - clock select 0 counts every cycle, 1 counts rising external edges.
// - prescale field divides the input by 1, 2, 4 or 8.
// - sync bit chooses synchronised or raw external clock; ignored internally.

module tmo_timer
  import tmo_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register port
  input wire logic [`TMO_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // clock inputs and oscillator status
  input wire logic extClockPin,
  input wire logic lpOscClock,
  input wire logic systemClockFromLpOsc,
  output logic lpOscEnable,
  // compare unit
  input wire logic [3:0] compareUnitMode,
  input wire logic compareTrigger,
  // interrupt request to the controller
  output logic overflowIrq,
  output logic overflowIrqPriority
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  tmo_bus_t bus;
  tmo_ctrl_t ctrl;
  logic [15:0] count;
  logic [7:0] highBuffer;
  logic overflowFlag;
  logic overflowIrqEnable;
  logic prioritySel;

  assign bus.addr = regAddr;
  assign bus.wdata = regWdata;
  assign bus.wr = regWr;
  assign bus.rd = regRd;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic wrLow;
  logic wrHigh;
  logic wrCtrl;
  logic wrFlags;
  logic wrEnables;
  logic wrPriority;
  logic rdLow;
  logic counterWrite;

  assign wrLow = bus.wr && (bus.addr == `TMO_REG_LOW);
  assign wrHigh = bus.wr && (bus.addr == `TMO_REG_HIGH);
  assign wrCtrl = bus.wr && (bus.addr == `TMO_REG_CTRL);
  assign wrFlags = bus.wr && (bus.addr == `TMO_REG_FLAGS);
  assign wrEnables = bus.wr && (bus.addr == `TMO_REG_ENABLES);
  assign wrPriority = bus.wr && (bus.addr == `TMO_REG_PRIORITY);
  assign rdLow = bus.rd && (bus.addr == `TMO_REG_LOW);

  // in wide mode a high-byte write only touches the buffer, not the count
  assign counterWrite = wrLow || (wrHigh && !ctrl.wideAccessMode);

  ////////////////////////////////////////////////////////////////////////////
  // external clock edge detection

  logic extSource;
  logic syncStage1;
  logic syncStage2;
  logic syncStage3;
  logic rawLast;
  logic syncEdge;
  logic rawEdge;
  logic extEdge;

  // an enabled oscillator takes over the external clock input
  assign extSource = ctrl.lpOscEnable ? lpOscClock : extClockPin;

  always_ff @(posedge mclk) begin
    if (srst) begin
      syncStage1 <= 1'b0;
      syncStage2 <= 1'b0;
      syncStage3 <= 1'b0;
      rawLast <= 1'b0;
    end else begin
      syncStage1 <= extSource;
      syncStage2 <= syncStage1;
      syncStage3 <= syncStage2;
      rawLast <= extSource;
    end
  end

  // raw path answers two cycles sooner but gives no metastability margin
  assign syncEdge = syncStage2 && !syncStage3;
  assign rawEdge = extSource && !rawLast;
  assign extEdge = ctrl.extClockSyncDisable ? rawEdge : syncEdge;

  ////////////////////////////////////////////////////////////////////////////
  // clock selection and prescaler

  logic inputTick;
  logic scaledTick;
  logic stepCount;

  // internal source is the instruction clock, one tick per mclk cycle
  assign inputTick = ctrl.clockSourceSelect ? extEdge : 1'b1;

  tmo_prescaler #(
    .CNT_W(`TMO_PRESCALE_W)
  ) u_prescaler (
    .mclk(mclk),
    .srst(srst),
    .clear(wrLow),
    .divSelect(ctrl.inputPrescaleSelect),
    .tickIn(inputTick && ctrl.counterOn),
    .tickOut(scaledTick)
  );

  assign stepCount = scaledTick && ctrl.counterOn;

  ////////////////////////////////////////////////////////////////////////////
  // compare unit trigger

  logic triggerArmed;
  logic triggerReset;

  // the trigger is acted on even with a raw external clock; results are then
  // only as good as the clock relation software has chosen
  assign triggerArmed = (compareUnitMode == `TMO_CMP_MODE_TRIGGER);
  assign triggerReset = triggerArmed && compareTrigger && !counterWrite;

  ////////////////////////////////////////////////////////////////////////////
  // counter next value

  logic wrap;
  logic [15:0] next_count;
  logic [15:0] writtenCount;
  logic [15:0] incremented;

  assign incremented = count + 16'h0001;
  assign wrap = stepCount && (count == `TMO_COUNT_MAX) && !counterWrite && !triggerReset;

  always_comb begin
    writtenCount = count;
    if (wrLow) begin
      if (ctrl.wideAccessMode) begin
        writtenCount = {highBuffer, bus.wdata};
      end else begin
        writtenCount = {count[15:8], bus.wdata};
      end
    end else if (wrHigh) begin
      writtenCount = {bus.wdata, count[7:0]};
    end
  end

  always_comb begin
    next_count = count;
    if (counterWrite) begin
      next_count = writtenCount;
    end else if (triggerReset) begin
      next_count = `TMO_COUNT_RESET;
    end else if (stepCount) begin
      next_count = incremented;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      count <= `TMO_COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // high-byte buffer

  logic [7:0] next_highBuffer;

  always_comb begin
    next_highBuffer = highBuffer;
    if (ctrl.wideAccessMode && wrHigh) begin
      next_highBuffer = bus.wdata;
    end else if (ctrl.wideAccessMode && rdLow) begin
      next_highBuffer = count[15:8];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      highBuffer <= `TMO_BYTE_RESET;
    end else begin
      highBuffer <= next_highBuffer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, flag, enable and priority registers

  logic next_overflowFlag;

  // hardware set wins over a software clear in the same cycle
  assign next_overflowFlag = wrap ? 1'b1 :
                             wrFlags ? bus.wdata[`TMO_OVF_BIT] : overflowFlag;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= tmo_ctrl_t'(`TMO_CTRL_RESET);
      overflowFlag <= 1'b0;
      overflowIrqEnable <= 1'b0;
      prioritySel <= 1'b0;
    end else begin
      if (wrCtrl) begin
        ctrl <= tmo_ctrl_t'(bus.wdata);
      end
      overflowFlag <= next_overflowFlag;
      if (wrEnables) begin
        overflowIrqEnable <= bus.wdata[`TMO_OVF_BIT];
      end
      if (wrPriority) begin
        prioritySel <= bus.wdata[`TMO_OVF_BIT];
      end
    end
  end

  assign lpOscEnable = ctrl.lpOscEnable;
  assign overflowIrq = overflowFlag && overflowIrqEnable;
  assign overflowIrqPriority = prioritySel;

  ////////////////////////////////////////////////////////////////////////////
  // read path, data one cycle after the strobe

  logic [7:0] readMux;
  logic [7:0] ctrlView;
  logic [7:0] highView;

  // the status bit reflects the live oscillator status, not a stored copy
  assign ctrlView = {ctrl.wideAccessMode, systemClockFromLpOsc,
                     ctrl[`TMO_CTRL_PRESCALE_HI:0]};
  assign highView = ctrl.wideAccessMode ? highBuffer : count[15:8];

  always_comb begin
    readMux = 8'h00;
    unique case (bus.addr)
      `TMO_REG_LOW: readMux = count[7:0];
      `TMO_REG_HIGH: readMux = highView;
      `TMO_REG_CTRL: readMux = ctrlView;
      `TMO_REG_FLAGS: readMux = {7'h00, overflowFlag};
      `TMO_REG_ENABLES: readMux = {7'h00, overflowIrqEnable};
      `TMO_REG_PRIORITY: readMux = {7'h00, prioritySel};
      default: readMux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else if (bus.rd) begin
      regRdata <= readMux;
    end else begin
      regRdata <= 8'h00;
    end
  end

endmodule

// *** dv/tmo_timer_asserts.sv ***
`timescale 1ns/1ps
module tmo_timer_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // status and requests
  input wire logic systemClockFromLpOsc,
  input wire logic lpOscEnable,
  input wire logic overflowIrq,
  input wire logic overflowIrqPriority
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside its slot");
  rd_unmap_a: assert property (regRd && regAddr > 3'h5 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  osc_set_a: assert property (regWr && regAddr == 3'h2 |=> lpOscEnable == $past(regWdata[3]))
    else $error("oscillator enable not loaded");
  osc_hold_a: assert property (!(regWr && regAddr == 3'h2) |=> $stable(lpOscEnable))
    else $error("oscillator enable moved");
  prio_set_a: assert property (regWr && regAddr == 3'h5 |=> overflowIrqPriority == $past(regWdata[0]))
    else $error("priority not loaded");
  irq_mask_a: assert property (regWr && regAddr == 3'h4 && !regWdata[0] |=> !overflowIrq)
    else $error("masked request still raised");
  status_rd_a: assert property (regRd && regAddr == 3'h2 |=> regRdata[6] == $past(systemClockFromLpOsc))
    else $error("clock status bit wrong");
  flag_pad_a: assert property (regRd && regAddr inside {[3'h3:3'h5]} |=> regRdata[7:1] == 7'h00)
    else $error("unused flag bits not zero");
endmodule

bind tmo_timer tmo_timer_asserts chk (.mclk(mclk), .srst(srst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .systemClockFromLpOsc(systemClockFromLpOsc), .lpOscEnable(lpOscEnable),
  .overflowIrq(overflowIrq), .overflowIrqPriority(overflowIrqPriority));

// *** dv/tmo_far_end.sv ***
`timescale 1ns/1ps
module tmo_far_end (
  // clock
  input wire logic mclk,
  // bench commands
  input wire logic fireReq,
  input wire logic extRun,
  // toward the timer
  output logic compareTrigger,
  output logic extClockPin
);
  logic [2:0] phase;
  initial begin
    compareTrigger = 1'b0;
    extClockPin = 1'b0;
    phase = 3'h0;
  end
  // one trigger pulse per request; the pin idles low between bursts
  always @(posedge mclk) begin
    compareTrigger <= fireReq;
    phase <= extRun ? phase + 3'h1 : 3'h0;
    extClockPin <= extRun & phase[2];
  end
endmodule

// *** dv/timer1_counter_16bit_test.sv ***
`timescale 1ns/1ps
module timer1_counter_16bit_test;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic systemClockFromLpOsc = 1'b0;
  logic [3:0] compareUnitMode = 4'hB;
  logic fireReq = 1'b0;
  logic extRun = 1'b0;
  logic lpOscClock = 1'b0;
  logic oscRun = 1'b0;
  logic [7:0] regRdata;
  logic [7:0] d;
  logic lpOscEnable, compareTrigger, extClockPin, overflowIrq, overflowIrqPriority;
  int miscompares = 0;
  int checked = 0;

  always #10 mclk = ~mclk;
  // oscillator stand-in: one rising edge every two cycles while running, low when stopped
  always @(posedge mclk) lpOscClock <= oscRun & ~lpOscClock;

  tmo_timer uut (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extClockPin(extClockPin),
    .lpOscClock(lpOscClock), .systemClockFromLpOsc(systemClockFromLpOsc),
    .lpOscEnable(lpOscEnable), .compareUnitMode(compareUnitMode),
    .compareTrigger(compareTrigger), .overflowIrq(overflowIrq),
    .overflowIrqPriority(overflowIrqPriority));
  tmo_far_end far (.mclk(mclk), .fireReq(fireReq), .extRun(extRun),
    .compareTrigger(compareTrigger), .extClockPin(extClockPin));

  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rc(input string n, input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 d = regRdata;
    chk(n, e, d);
  endtask
  // the count sees k+2 edges with the counter on
  task automatic run(input logic [7:0] c, input int k);
    wr(3'h2, c);
    repeat (k) @(posedge mclk);
    wr(3'h2, 8'h00);
  endtask
  task automatic pulse;
    @(posedge mclk);
    fireReq <= 1'b1;
    @(posedge mclk);
    fireReq <= 1'b0;
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a < 8; a++) rc("reset", 3'(a), 8'h00);
    systemClockFromLpOsc <= 1'b1;
    wr(3'h2, 8'h40);
    rc("status", 3'h2, 8'h40);
    systemClockFromLpOsc <= 1'b0;
    wr(3'h5, 8'h01);
    #1;
    chk("prio", 8'h01, {7'h00, overflowIrqPriority});
    wr(3'h5, 8'h00);
    wr(3'h6, 8'hFF);
    rc("unmapped", 3'h6, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_presc;
    for (int p = 0; p < 4; p++) begin
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      run(8'h01 | 8'(p << 4), 30);
      rc("prescale", 3'h0, 8'(32 >> p));
    end
    rc("frozen", 3'h0, 8'h04);
    wr(3'h0, 8'h00);
    run(8'h31, 2);
    wr(3'h1, 8'h00);
    run(8'h31, 2);
    rc("high keeps", 3'h0, 8'h01);
    wr(3'h0, 8'h00);
    run(8'h31, 2);
    wr(3'h0, 8'h00);
    run(8'h31, 2);
    rc("low clears", 3'h0, 8'h00);
    $display("prescale test done");
  endtask
  task automatic t_ovf;
    wr(3'h4, 8'h01);
    wr(3'h1, 8'hFF);
    wr(3'h0, 8'hF0);
    wr(3'h2, 8'h01);
    for (int i = 0; i < 40 && overflowIrq !== 1'b1; i++) @(posedge mclk);
    wr(3'h2, 8'h00);
    rc("flag", 3'h3, 8'h01);
    rc("wrap", 3'h1, 8'h00);
    chk("irq on", 8'h01, {7'h00, overflowIrq});
    wr(3'h4, 8'h00);
    #1;
    chk("irq off", 8'h00, {7'h00, overflowIrq});
    rc("sticky", 3'h3, 8'h01);
    wr(3'h3, 8'h00);
    rc("cleared", 3'h3, 8'h00);
    $display("overflow test done");
  endtask
  task automatic t_trig;
    wr(3'h1, 8'h12);
    wr(3'h0, 8'h55);
    pulse;
    rc("trig low", 3'h0, 8'h00);
    rc("trig high", 3'h1, 8'h00);
    rc("no flag", 3'h3, 8'h00);
    compareUnitMode <= 4'hA;
    wr(3'h0, 8'h55);
    pulse;
    rc("other mode", 3'h0, 8'h55);
    compareUnitMode <= 4'hB;
    // the partner registers the trigger, so the write strobe goes out one cycle later
    fork
      pulse;
      begin
        @(posedge mclk);
        wr(3'h0, 8'h77);
      end
    join
    rc("write wins", 3'h0, 8'h77);
    $display("trigger test done");
  endtask
  task automatic t_wide;
    wr(3'h1, 8'h12);
    wr(3'h0, 8'h34);
    wr(3'h2, 8'h80);
    rc("snap low", 3'h0, 8'h34);
    rc("snap high", 3'h1, 8'h12);
    wr(3'h1, 8'hAB);
    rc("buffer", 3'h1, 8'hAB);
    wr(3'h2, 8'h00);
    rc("live kept", 3'h1, 8'h12);
    wr(3'h2, 8'h80);
    wr(3'h0, 8'hCD);
    wr(3'h2, 8'h00);
    rc("load high", 3'h1, 8'hAB);
    rc("load low", 3'h0, 8'hCD);
    $display("wide test done");
  endtask
  task automatic t_ext;
    logic [7:0] modes [2] = '{8'h03, 8'h07};
    for (int m = 0; m < 2; m++) begin
      wr(3'h0, 8'h00);
      wr(3'h2, modes[m]);
      extRun <= 1'b1;
      repeat (40) @(posedge mclk);
      extRun <= 1'b0;
      repeat (8) @(posedge mclk);
      wr(3'h2, 8'h00);
      rc("ext edges", 3'h0, 8'h05);
    end
    $display("external test done");
  endtask
  task automatic t_rtc;
    wr(3'h4, 8'h01);
    wr(3'h1, 8'hFF);
    wr(3'h2, 8'h0F);
    #1;
    chk("osc enable", 8'h01, {7'h00, lpOscEnable});
    oscRun <= 1'b1;
    for (int i = 0; i < 1000 && overflowIrq !== 1'b1; i++) @(posedge mclk);
    oscRun <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(3'h2, 8'h00);
    rc("osc flag", 3'h3, 8'h01);
    rc("osc wrap", 3'h1, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h00);
    $display("oscillator test done");
  endtask

  ////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    t_reset;
    t_presc;
    t_ovf;
    t_trig;
    t_wide;
    t_ext;
    t_rtc;
    end_of_test;
  end
  // whole run is about a thousand cycles; this is ample headroom
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
endmodule
